// >>> logic/mmd_top.sv
// Memory map decoder and program counter start logic
`timescale 1ns/100ps
`include "mmd_defs.svh"
module mmd_top
    import mmd_pkg::*;
#(
    parameter mmd_variant_e VARIANT = MMD_VAR_PROM
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_fetch_req,
    input wire logic [1:0] i_fetch_len,
    input wire logic i_br_take,
    input wire logic [15:0] i_br_target,
    input wire logic i_int_ack,
    input wire logic [4:0] i_int_vec_idx,
    input wire logic i_dreq,
    input wire logic i_dwr,
    input wire logic i_dstack,
    input wire logic [15:0] i_daddr,
    input wire logic i_ims_wr,
    input wire logic [7:0] i_ims_wdata,
    input wire logic i_mem_ack,
    input wire logic [7:0] i_mem_rdata,
    output logic [15:0] o_pc,
    output logic o_pc_valid,
    output logic o_boot_rd,
    output logic [15:0] o_boot_addr,
    output mmd_region_e o_fetch_region,
    output logic o_fetch_ok,
    output mmd_region_e o_data_region,
    output logic o_data_ok,
    output logic o_data_we,
    output logic [7:0] o_ims,
    output logic [16:0] o_rom_size
);
    if (VARIANT > MMD_VAR_PROM) begin : g_bad_variant
        $error("mmd_top: unsupported variant");
    end

    localparam bit REVISED = VARIANT == MMD_VAR_PROM
        || VARIANT == MMD_VAR_32K || VARIANT == MMD_VAR_40K;
    localparam bit LARGE = VARIANT == MMD_VAR_48K
        || VARIANT == MMD_VAR_60K || VARIANT == MMD_VAR_PROM;

    function automatic logic [16:0] rom_cap(input mmd_variant_e v);
        unique case (v)
            MMD_VAR_32K: rom_cap = `MMD_ROM_32K;
            MMD_VAR_40K: rom_cap = `MMD_ROM_40K;
            MMD_VAR_48K: rom_cap = `MMD_ROM_48K;
            default: rom_cap = `MMD_ROM_60K;
        endcase
    endfunction

    function automatic logic [16:0] ims_rom(input logic [7:0] memory_size_select);
        unique case (memory_size_select)
            `MMD_IMS_32K: ims_rom = `MMD_ROM_32K;
            `MMD_IMS_40K: ims_rom = `MMD_ROM_40K;
            `MMD_IMS_48K: ims_rom = `MMD_ROM_48K;
            default: ims_rom = `MMD_ROM_60K;
        endcase
    endfunction

    function automatic logic region_is_ram(input mmd_region_e r);
        region_is_ram = r == MMD_RG_EXP || r == MMD_RG_DISP
            || r == MMD_RG_BUF || r == MMD_RG_HSR || r == MMD_RG_GPR
            || r == MMD_RG_SFR;
    endfunction

    // Memory size select register
    logic [7:0] ims_q;
    logic [7:0] ims_d;
    // fixed reset value on revised parts
    assign ims_d = i_ims_wr ? i_ims_wdata : ims_q;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n)
            ims_q <= `MMD_IMS_RST;
        else
            ims_q <= ims_d;
    end
    assign o_ims = ims_q;

    wire [16:0] cap_var = rom_cap(VARIANT);
    wire [16:0] cap_ims = ims_rom(ims_q);
    wire [16:0] rom_size = REVISED && cap_ims < cap_var ? cap_ims
        : cap_var;
    wire exp_en = LARGE;
    assign o_rom_size = rom_size;

    // Reset vector loader
    logic boot_done;
    logic [15:0] boot_vec;
    mmd_vec_loader u_vl (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_rd_ack(i_mem_ack),
        .i_rd_data(i_mem_rdata),
        .o_rd_req(o_boot_rd),
        .o_rd_addr(o_boot_addr),
        .o_done(boot_done),
        .o_vector(boot_vec)
    );

    // Program counter
    logic [15:0] pc_q;
    logic [15:0] pc_d;
    logic boot_seen_q;
    wire boot_load = boot_done && !boot_seen_q;
    // vector slot address, two bytes each
    wire [15:0] int_target = {10'h000, i_int_vec_idx, 1'b0};
    wire [15:0] pc_seq = pc_q + {14'h0000, i_fetch_len};
    assign pc_d = boot_load ? boot_vec :
                  !boot_seen_q ? pc_q :
                  i_int_ack ? int_target :
                  i_br_take ? i_br_target :
                  i_fetch_req ? pc_seq : pc_q;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pc_q <= 16'h0000;
            boot_seen_q <= 1'b0;
        end else begin
            pc_q <= pc_d;
            boot_seen_q <= boot_done;
        end
    end
    assign o_pc = pc_q;
    assign o_pc_valid = boot_seen_q;

    // Fetch and data decode
    mmd_region_dec u_fdec (
        .i_addr(pc_q),
        .i_rom_size(rom_size),
        .i_exp_en(exp_en),
        .o_region(o_fetch_region)
    );
    mmd_region_dec u_ddec (
        .i_addr(i_daddr),
        .i_rom_size(rom_size),
        .i_exp_en(exp_en),
        .o_region(o_data_region)
    );
    // execution allowed in ROM and expansion only
    assign o_fetch_ok = boot_seen_q && (o_fetch_region == MMD_RG_VEC
        || o_fetch_region == MMD_RG_TABLE_CALL_INSTRUCTION || o_fetch_region == MMD_RG_ROM
        || o_fetch_region == MMD_RG_EXP);
    wire stack_ok = o_data_region == MMD_RG_HSR
        || o_data_region == MMD_RG_GPR;
    // gaps refused; relies on software for SFR holes
    assign o_data_ok = i_dreq && o_data_region != MMD_RG_RSV
        && (!i_dstack || stack_ok);
    assign o_data_we = o_data_ok && i_dwr
        && region_is_ram(o_data_region);

    property p_ims_reset;
        @(posedge i_clk_sys) $rose(i_rst_n) |-> ims_q == `MMD_IMS_RST;
    endproperty
    a_ims_reset: assert property (p_ims_reset)
        else $error("size select not at reset value");
    property p_pc_boot;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        boot_load |=> pc_q == $past(boot_vec);
    endproperty
    a_pc_boot: assert property (p_pc_boot)
        else $error("pc not loaded from reset vector");
    property p_pc_seq;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        boot_seen_q && !i_int_ack && !i_br_take && i_fetch_req
        |=> pc_q == $past(pc_q) + 16'($past(i_fetch_len));
    endproperty
    a_pc_seq: assert property (p_pc_seq)
        else $error("pc advance wrong");
    property p_pc_br;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        boot_seen_q && !i_int_ack && i_br_take
        |=> pc_q == $past(i_br_target);
    endproperty
    a_pc_br: assert property (p_pc_br)
        else $error("branch target not loaded");
    property p_pc_int;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        boot_seen_q && i_int_ack |=> pc_q[15:6] == 10'h000 && !pc_q[0];
    endproperty
    a_pc_int: assert property (p_pc_int)
        else $error("interrupt vector outside table");
    property p_no_exec_hsr;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        pc_q >= `MMD_HSR_BEG && pc_q <= `MMD_HSR_END |-> !o_fetch_ok;
    endproperty
    a_no_exec_hsr: assert property (p_no_exec_hsr)
        else $error("fetch allowed from high-speed RAM");
    property p_stack_exp;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_dstack && i_daddr >= `MMD_EXP_BEG && i_daddr <= `MMD_EXP_END
        |-> !o_data_ok;
    endproperty
    a_stack_exp: assert property (p_stack_exp)
        else $error("stack allowed in expansion RAM");
    property p_gap;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_daddr >= `MMD_GAP_BEG && i_daddr < `MMD_BUF_BEG |-> !o_data_we;
    endproperty
    a_gap: assert property (p_gap)
        else $error("write reached reserved gap");
    property p_sfr;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_daddr >= `MMD_SFR_BEG |-> o_data_region == MMD_RG_SFR;
    endproperty
    a_sfr: assert property (p_sfr)
        else $error("register window misdecoded");
    property p_gpr;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_daddr >= `MMD_GPR_BEG && i_daddr < `MMD_SFR_BEG
        |-> o_data_region == MMD_RG_GPR;
    endproperty
    a_gpr: assert property (p_gpr)
        else $error("register banks misdecoded");
    property p_vec;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_daddr <= `MMD_VEC_END |-> o_data_region == MMD_RG_VEC;
    endproperty
    a_vec: assert property (p_vec)
        else $error("vector table misdecoded");
    property p_boot_time;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        o_boot_rd && i_mem_ack ##1 o_boot_rd && i_mem_ack
        |-> ##[1:2] o_pc_valid;
    endproperty
    a_boot_time: assert property (p_boot_time)
        else $error("boot did not finish after two bytes");
    property p_table_call_instruction;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_daddr >= `MMD_TABLE_CALL_INSTRUCTION_BEG && i_daddr <= `MMD_TABLE_CALL_INSTRUCTION_END
        |-> o_data_region == MMD_RG_TABLE_CALL_INSTRUCTION;
    endproperty
    a_table_call_instruction: assert property (p_table_call_instruction)
        else $error("table-call area misdecoded");
    property p_fixed_area_call_instruction;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        o_pc_valid && pc_q >= `MMD_FIXED_AREA_CALL_INSTRUCTION_BEG && pc_q <= `MMD_FIXED_AREA_CALL_INSTRUCTION_END
        |-> o_fetch_ok;
    endproperty
    a_fixed_area_call_instruction: assert property (p_fixed_area_call_instruction)
        else $error("fixed-area call entry not executable");
    property p_hsr;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_daddr >= `MMD_HSR_BEG && i_daddr < `MMD_GPR_BEG
        |-> o_data_region == MMD_RG_HSR;
    endproperty
    a_hsr: assert property (p_hsr)
        else $error("high-speed RAM misdecoded");
    property p_exp_map;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_daddr >= `MMD_EXP_BEG && i_daddr <= `MMD_EXP_END
        |-> o_data_region == (LARGE ? MMD_RG_EXP : MMD_RG_RSV);
    endproperty
    a_exp_map: assert property (p_exp_map)
        else $error("expansion RAM misdecoded");
    property p_exp_exec;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        LARGE && o_pc_valid && pc_q >= `MMD_EXP_BEG
        && pc_q <= `MMD_EXP_END |-> o_fetch_ok;
    endproperty
    a_exp_exec: assert property (p_exp_exec)
        else $error("expansion RAM not executable");
    property p_buf;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_daddr >= `MMD_BUF_BEG && i_daddr <= `MMD_BUF_END
        |-> o_data_region == MMD_RG_BUF;
    endproperty
    a_buf: assert property (p_buf)
        else $error("buffer RAM misdecoded");
    property p_disp;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_daddr >= `MMD_DISP_BEG && i_daddr <= `MMD_DISP_END
        |-> o_data_region == MMD_RG_DISP;
    endproperty
    a_disp: assert property (p_disp)
        else $error("display RAM misdecoded");
    property p_disp_we;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_dreq && i_dwr && !i_dstack && i_daddr >= `MMD_DISP_BEG
        && i_daddr <= `MMD_DISP_END |-> o_data_we;
    endproperty
    a_disp_we: assert property (p_disp_we)
        else $error("display RAM write refused");
    property p_stack_hsr;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_dreq && i_dstack && i_daddr >= `MMD_HSR_BEG
        && i_daddr <= `MMD_HSR_END |-> o_data_ok;
    endproperty
    a_stack_hsr: assert property (p_stack_hsr)
        else $error("stack refused in high-speed RAM");
    property p_rom_in;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_daddr > `MMD_TABLE_CALL_INSTRUCTION_END && {1'b0, i_daddr} < o_rom_size
        |-> o_data_region == MMD_RG_ROM;
    endproperty
    a_rom_in: assert property (p_rom_in)
        else $error("internal ROM misdecoded");
    property p_rom_lim;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        {1'b0, i_daddr} >= o_rom_size && i_daddr < `MMD_EXP_BEG
        |-> o_data_region == MMD_RG_RSV;
    endproperty
    a_rom_lim: assert property (p_rom_lim)
        else $error("address past ROM end not reserved");
    property p_rom_we;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        {1'b0, i_daddr} < o_rom_size |-> !o_data_we;
    endproperty
    a_rom_we: assert property (p_rom_we)
        else $error("write reached ROM");
    property p_ims_wr;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        i_ims_wr |=> o_ims == $past(i_ims_wdata);
    endproperty
    a_ims_wr: assert property (p_ims_wr)
        else $error("size select write lost");
    property p_ims_hold;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        !i_ims_wr |=> $stable(o_ims);
    endproperty
    a_ims_hold: assert property (p_ims_hold)
        else $error("size select changed without write");
    property p_pc_hold;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        o_pc_valid && !i_int_ack && !i_br_take && !i_fetch_req
        |=> $stable(pc_q);
    endproperty
    a_pc_hold: assert property (p_pc_hold)
        else $error("pc moved while idle");
    property p_boot_addr;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        o_boot_rd |-> o_boot_addr[15:1] == 15'h0000;
    endproperty
    a_boot_addr: assert property (p_boot_addr)
        else $error("boot read outside reset vector");
    c_boot: cover property (@(posedge i_clk_sys) $rose(o_pc_valid));
    c_branch: cover property (@(posedge i_clk_sys)
        o_pc_valid && i_br_take);
    c_stack: cover property (@(posedge i_clk_sys) o_data_ok && i_dstack);
    c_ims: cover property (@(posedge i_clk_sys) i_ims_wr);
endmodule

// >>> pkg/mmd_defs.svh
// Address map constants and the function list for the memory map decoder
// Function
// - Decode a flat 64 KB space with 16-bit addresses for fetch and data.
// - Bytes 0000H to 003FH form the vector table.
// - Vector entries hold low byte at even, high byte at odd address.
// - Reset and interrupts branch through their own vector entries; interrupts load the entry address itself into the program counter.
// - Region 0040H to 007FH is the table-call entry table.
// - Fixed-area call reaches entries from 0800H to 0FFFH directly.
// - ROM from zero is 32768, 40960, 49152 or 61440 bytes per variant.
// - High-speed RAM of 1024 bytes sits at FB00H to FEFFH.
// - FEE0H to FEFFH hold four banks of eight registers.
// - High-speed RAM never serves as an execution region.
// - High-speed RAM may be used for stack pushes and pops.
// - Larger variants map 1024 bytes expansion RAM at F400H, data and code.
// - Expansion RAM must not hold the stack.
// - Buffer RAM FAC0H to FAFFH behaves as serial buffer or plain RAM.
// - Display RAM FA30H to FA7FH is also ordinary RAM.
// - FF00H to FFFFH decodes to the special-function registers.
// - Memory-size select resets to CFH on revised and programmable parts.
// - Program counter advances by each fetched instruction length.
// - Taken branch loads the program counter from immediate or register.
// - Reset loads the program counter from bytes at 0000H and 0001H.
`ifndef MMD_DEFS_SVH
`define MMD_DEFS_SVH
`define MMD_VEC_END 16'h003f
`define MMD_TABLE_CALL_INSTRUCTION_BEG 16'h0040
`define MMD_TABLE_CALL_INSTRUCTION_END 16'h007f
`define MMD_FIXED_AREA_CALL_INSTRUCTION_BEG 16'h0800
`define MMD_FIXED_AREA_CALL_INSTRUCTION_END 16'h0fff
`define MMD_EXP_BEG 16'hf400
`define MMD_EXP_END 16'hf7ff
`define MMD_DISP_BEG 16'hfa30
`define MMD_DISP_END 16'hfa7f
`define MMD_BUF_BEG 16'hfac0
`define MMD_BUF_END 16'hfaff
`define MMD_GAP_BEG 16'hfa80
`define MMD_HSR_BEG 16'hfb00
`define MMD_HSR_END 16'hfeff
`define MMD_GPR_BEG 16'hfee0
`define MMD_SFR_BEG 16'hff00
`define MMD_RST_VEC 16'h0000
`define MMD_IMS_RST 8'hcf
`define MMD_ROM_32K 17'h08000
`define MMD_ROM_40K 17'h0a000
`define MMD_ROM_48K 17'h0c000
`define MMD_ROM_60K 17'h0f000
`define MMD_IMS_32K 8'hc8
`define MMD_IMS_40K 8'hca
`define MMD_IMS_48K 8'hcc
`endif

// >>> pkg/mmd_pkg.sv
// Types shared by the memory map decoder
package mmd_pkg;
    typedef enum logic [3:0] {
        MMD_RG_VEC, MMD_RG_TABLE_CALL_INSTRUCTION, MMD_RG_ROM, MMD_RG_EXP, MMD_RG_DISP,
        MMD_RG_BUF, MMD_RG_HSR, MMD_RG_GPR, MMD_RG_SFR, MMD_RG_RSV
    } mmd_region_e;
    typedef enum logic [2:0] {
        MMD_VAR_32K, MMD_VAR_40K, MMD_VAR_48K, MMD_VAR_60K, MMD_VAR_PROM
    } mmd_variant_e;
endpackage

// >>> logic/mmd_region_dec.sv
// Region decoder for one 16-bit address
`timescale 1ns/100ps
`include "mmd_defs.svh"
module mmd_region_dec
    import mmd_pkg::*;
(
    input wire logic [15:0] i_addr,
    input wire logic [16:0] i_rom_size,
    input wire logic i_exp_en,
    output mmd_region_e o_region
);
    // Region decode over the full space
    // flat map
    wire in_rom = {1'b0, i_addr} < i_rom_size;
    wire in_vec = i_addr <= `MMD_VEC_END;
    wire in_table_call_instruction = i_addr >= `MMD_TABLE_CALL_INSTRUCTION_BEG && i_addr <= `MMD_TABLE_CALL_INSTRUCTION_END;
    wire in_exp = i_exp_en && i_addr >= `MMD_EXP_BEG
        && i_addr <= `MMD_EXP_END;
    wire in_disp = i_addr >= `MMD_DISP_BEG && i_addr <= `MMD_DISP_END;
    wire in_buf = i_addr >= `MMD_BUF_BEG && i_addr <= `MMD_BUF_END;
    wire in_hsr = i_addr >= `MMD_HSR_BEG && i_addr <= `MMD_HSR_END;
    wire in_gpr = i_addr >= `MMD_GPR_BEG && in_hsr;
    wire in_sfr = i_addr >= `MMD_SFR_BEG;
    assign o_region = in_vec ? MMD_RG_VEC :
                      in_table_call_instruction ? MMD_RG_TABLE_CALL_INSTRUCTION :
                      in_rom ? MMD_RG_ROM :
                      in_exp ? MMD_RG_EXP :
                      in_disp ? MMD_RG_DISP :
                      in_buf ? MMD_RG_BUF :
                      in_gpr ? MMD_RG_GPR :
                      in_hsr ? MMD_RG_HSR :
                      in_sfr ? MMD_RG_SFR : MMD_RG_RSV;
endmodule

// >>> logic/mmd_vec_loader.sv
// Reset vector fetch sequencer
`timescale 1ns/100ps
`include "mmd_defs.svh"
module mmd_vec_loader
    import mmd_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_rd_ack,
    input wire logic [7:0] i_rd_data,
    output logic o_rd_req,
    output logic [15:0] o_rd_addr,
    output logic o_done,
    output logic [15:0] o_vector
);
    typedef enum logic [1:0] {ST_LO, ST_HI, ST_DONE} mmd_vl_e;
    mmd_vl_e state_q;
    logic [7:0] lo_q;
    logic [15:0] vec_q;
    assign o_rd_req = state_q != ST_DONE;
    assign o_rd_addr = `MMD_RST_VEC | {15'h0000, state_q == ST_HI};
    assign o_done = state_q == ST_DONE;
    assign o_vector = vec_q;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_LO;
            lo_q <= 8'h00;
            vec_q <= 16'h0000;
        end else if (i_rd_ack) begin
            unique case (state_q)
                ST_LO: begin
                    lo_q <= i_rd_data;
                    state_q <= ST_HI;
                end
                ST_HI: begin
                    vec_q <= {i_rd_data, lo_q};
                    state_q <= ST_DONE;
                end
                ST_DONE: state_q <= ST_DONE;
            endcase
        end
    end
endmodule

// >>> tb/mmd_boot_mem.sv
// Boot memory model answering the reset vector reads
`timescale 1ns/100ps
module mmd_boot_mem (
    input wire logic i_clk_sys,
    input wire logic i_boot_rd,
    input wire logic [15:0] i_boot_addr,
    input wire logic [15:0] i_vec,
    input wire logic [3:0] i_delay,
    output logic o_ack,
    output logic [7:0] o_rdata
);
    logic [3:0] wait_cnt;
    logic hit;
    // only bytes 0000H and 0001H hold the vector
    assign hit = (i_boot_addr[15:1] == 15'h0000);
    initial begin
        o_ack = 1'b0;
        o_rdata = 8'h5a;
        wait_cnt = 4'h0;
    end
    always @(negedge i_clk_sys) begin
        if (i_boot_rd && wait_cnt >= i_delay) begin
            o_ack <= 1'b1;
            // low byte at even, high byte at odd address
            o_rdata <= !hit ? ~o_rdata :
                i_boot_addr[0] ? i_vec[15:8] : i_vec[7:0];
            wait_cnt <= 4'h0;
        end else begin
            // Released data line toggles so stale bytes never match
            o_ack <= 1'b0;
            o_rdata <= ~o_rdata;
            wait_cnt <= i_boot_rd ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule

// >>> tb/testbench.sv
// Self-checking testbench for the memory map decoder
`timescale 1ns/100ps
module testbench
    import mmd_pkg::*;
;
    logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_fetch_req = 1'b0;
    logic [1:0] i_fetch_len = 2'h0;
    logic i_br_take = 1'b0, i_int_ack = 1'b0;
    logic [15:0] i_br_target = 16'h0000, i_daddr = 16'h0000;
    logic [4:0] i_int_vec_idx = 5'h00;
    logic i_dreq = 1'b0, i_dwr = 1'b0, i_dstack = 1'b0, i_ims_wr = 1'b0;
    logic [7:0] i_ims_wdata = 8'h00, i_mem_rdata, o_ims;
    logic i_mem_ack, o_pc_valid, o_boot_rd, o_fetch_ok, o_data_ok;
    logic o_data_we;
    logic [15:0] o_pc, o_boot_addr, vec = 16'h0000;
    logic [3:0] dly = 4'h0;
    mmd_region_e o_fetch_region, o_data_region;
    logic [16:0] o_rom_size;
    int err_count = 0, comparisons = 0;
    always #12.5 i_clk_sys = ~i_clk_sys;
    mmd_top #(.VARIANT(MMD_VAR_PROM)) mmd_top_inst (.i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n), .i_fetch_req(i_fetch_req),
        .i_fetch_len(i_fetch_len), .i_br_take(i_br_take),
        .i_br_target(i_br_target), .i_int_ack(i_int_ack),
        .i_int_vec_idx(i_int_vec_idx), .i_dreq(i_dreq), .i_dwr(i_dwr),
        .i_dstack(i_dstack), .i_daddr(i_daddr), .i_ims_wr(i_ims_wr),
        .i_ims_wdata(i_ims_wdata), .i_mem_ack(i_mem_ack),
        .i_mem_rdata(i_mem_rdata), .o_pc(o_pc), .o_pc_valid(o_pc_valid),
        .o_boot_rd(o_boot_rd), .o_boot_addr(o_boot_addr),
        .o_fetch_region(o_fetch_region), .o_fetch_ok(o_fetch_ok),
        .o_data_region(o_data_region), .o_data_ok(o_data_ok),
        .o_data_we(o_data_we), .o_ims(o_ims), .o_rom_size(o_rom_size));
    mmd_boot_mem mmd_boot_mem_inst (.i_clk_sys(i_clk_sys),
        .i_boot_rd(o_boot_rd), .i_boot_addr(o_boot_addr), .i_vec(vec),
        .i_delay(dly), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
    task automatic tally_and_finish();
        $display("Counts: %0d compares, %0d mismatches", comparisons,
            err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [16:0] got, exp, input string m);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic do_reset(input logic [15:0] v, input logic [3:0] d);
        int n;
        @(negedge i_clk_sys);
        vec = v;
        dly = d;
        i_rst_n = 1'b0;
        repeat (8) @(negedge i_clk_sys);
        i_rst_n = 1'b1;
        for (n = 0; n < 60 && o_pc_valid !== 1'b1; n++)
            @(negedge i_clk_sys);
        if (o_pc_valid !== 1'b1) begin
            err_count++;
            $display("BAD %0t boot never finished", $time);
            return;
        end
        chk(o_pc, v, "reset pc");
        chk(o_ims, 8'hcf, "size select reset");
        chk(o_boot_rd, 1'b0, "boot read stays low");
        $display("Test reset done");
    endtask
    task automatic pc_op(input logic f, input logic [1:0] l,
        input logic b, input logic [15:0] t, input logic a,
        input logic [4:0] x, input logic [15:0] exp, input string m);
        i_fetch_req = f;
        i_fetch_len = l;
        i_br_take = b;
        i_br_target = t;
        i_int_ack = a;
        i_int_vec_idx = x;
        @(negedge i_clk_sys);
        chk(o_pc, exp, m);
    endtask
    task automatic test_pc();
        pc_op(1, 3, 0, 0, 0, 0, 16'h1237, "fetch 3");
        pc_op(1, 1, 0, 0, 0, 0, 16'h1238, "fetch 1");
        pc_op(1, 1, 1, 16'hf400, 0, 0, 16'hf400, "branch");
        chk(o_fetch_region, 17'h3, "exp fetch region");
        chk(o_fetch_ok, 1'b1, "exp executable");
        pc_op(0, 0, 1, 16'hfb10, 0, 0, 16'hfb10, "branch hsr");
        chk(o_fetch_ok, 1'b0, "hsr not executable");
        pc_op(0, 0, 1, 16'h0800, 0, 0, 16'h0800, "branch fixed_area_call_instruction");
        chk(o_fetch_ok, 1'b1, "fixed_area_call_instruction executable");
        pc_op(0, 0, 1, 16'h0, 1, 31, 16'h003e, "break vec");
        pc_op(1, 2, 0, 0, 1, 2, 16'h0004, "watchdog vec");
        pc_op(0, 0, 0, 0, 1, 14, 16'h001c, "key vec");
        {i_fetch_req, i_br_take, i_int_ack} = 3'b000;
        $display("Test program counter done");
    endtask
    localparam logic [19:0] MAP [23] = '{20'h00000, 20'h003f0,
        20'h00401, 20'h007f1, 20'h00802, 20'h08002, 20'hefff2,
        20'hf0009, 20'hf4003, 20'hf7ff3, 20'hf8009, 20'hfa2f9,
        20'hfa304, 20'hfa7f4, 20'hfa809, 20'hfac05, 20'hfaff5,
        20'hfb006, 20'hfedf6, 20'hfee07, 20'hfeff7, 20'hff008,
        20'hffff8};
    task automatic test_map();
        foreach (MAP[k]) begin
            i_daddr = MAP[k][19:4];
            @(negedge i_clk_sys);
            chk(o_data_region, MAP[k][3:0], "region");
        end
        chk(o_rom_size, 17'h0f000, "rom size 60k");
        $display("Test address map done");
    endtask
    // Address, write, stack, ok (2 = ignore), write enable
    localparam logic [20:0] ACC [11] = '{{16'hfb00, 5'b11011},
        {16'hfb00, 5'b01010}, {16'hf400, 5'b11000},
        {16'hf400, 5'b10011}, {16'h0100, 5'b10100},
        {16'hf000, 5'b00000}, {16'hfa80, 5'b10000},
        {16'hfa30, 5'b10011}, {16'hfac0, 5'b10011},
        {16'hff05, 5'b10011}, {16'hfee0, 5'b11011}};
    task automatic test_access();
        i_dreq = 1'b1;
        foreach (ACC[k]) begin
            {i_daddr, i_dwr, i_dstack} = ACC[k][20:3];
            @(negedge i_clk_sys);
            if (ACC[k][2:1] != 2'b10)
                chk(o_data_ok, ACC[k][1], "data ok");
            chk(o_data_we, ACC[k][0], "data we");
        end
        i_dreq = 1'b0;
        @(negedge i_clk_sys);
        chk(o_data_ok, 1'b0, "no request");
        $display("Test data access done");
    endtask
    task automatic ims_case(input logic [7:0] v, input logic [16:0] sz);
        i_ims_wr = 1'b1;
        i_ims_wdata = v;
        @(negedge i_clk_sys);
        i_ims_wr = 1'b0;
        chk(o_ims, v, "size select");
        chk(o_rom_size, sz, "rom size");
        i_daddr = sz[15:0] - 16'h1;
        @(negedge i_clk_sys);
        chk(o_data_region, 17'h2, "last rom byte");
        i_daddr = sz[15:0];
        @(negedge i_clk_sys);
        chk(o_data_region, 17'h9, "past rom end");
    endtask
    task automatic test_ims();
        ims_case(8'hc8, 17'h08000);
        ims_case(8'hca, 17'h0a000);
        ims_case(8'hcc, 17'h0c000);
        $display("Test size select done");
    endtask
    initial begin
        do_reset(16'h1234, 4'h2);
        if (err_count == 0) begin
            test_pc();
            test_map();
            test_access();
            test_ims();
            do_reset(16'hbeef, 4'h0);
        end
        tally_and_finish();
    end
endmodule
